// File: design/nasw_node_status.sv
/*
 * node address selection, slice unit numbering and the 16-bit status word.
 * assumes all inputs are synchronous to i_core_clk and that i_reset models power-on.
 */
// Operation
// - switches read as tens and ones digit
// - own master: switch 01-99 is address
// - switch 00 uses stored address 1-65535
// - foreign master uses tool assigned address
// - switches sampled once at power-on
// - factory switch and stored address zero
// - duplicate address flags error, stops operation
// - slices numbered from one, left to right
// - extension modules and cables are skipped
// - slice numbers independent of node address
// - status word sent with cyclic input
// - bit 0 slice bus communication error
// - bit 2 any slice minor error
// - bit 4 any slice major error
// - bit 12 power-on time threshold reached
// - bit 13 automatic restore failed
// - bit 14 is OR of bits 0-13
// - bit 15 set while I/O exchange normal
`timescale 1ns/1ps
`default_nettype none

module nasw_node_status (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [nasw_pkg::DIGIT_W-1:0] i_rotary_tens,
    input wire logic [nasw_pkg::DIGIT_W-1:0] i_rotary_ones,
    input wire logic i_master_own,
    input wire logic i_store_wr,
    input wire logic [nasw_pkg::ADDR_W-1:0] i_store_addr,
    input wire logic i_tool_wr,
    input wire logic [nasw_pkg::ADDR_W-1:0] i_tool_addr,
    input wire logic i_dup_detect,
    input wire nasw_pkg::nasw_slice_t i_slice,
    input wire logic i_bus_comm_err,
    input wire logic i_pot_tick,
    input wire logic [nasw_pkg::POT_W-1:0] i_pot_limit,
    input wire logic i_restore_done,
    input wire logic i_restore_fail,
    input wire logic i_io_exchange,
    input wire logic i_cyc_req,
    output logic [nasw_pkg::ADDR_W-1:0] o_node_addr,
    output logic o_addr_valid,
    output logic o_addr_error,
    output logic o_numbering_done,
    output logic [nasw_pkg::SLOTS*nasw_pkg::NUM_W-1:0] o_unit_num,
    output logic [15:0] o_status_word,
    output logic [15:0] o_cyc_word,
    output logic o_cyc_valid
);

    function automatic logic [nasw_pkg::SW_W-1:0] sw_value(
        input logic [nasw_pkg::DIGIT_W-1:0] tens,
        input logic [nasw_pkg::DIGIT_W-1:0] ones
    );
        logic [nasw_pkg::SW_W-1:0] t;
        t = {3'h0, tens};
        sw_value = nasw_pkg::SW_W'((t << 3) + (t << 1) + {3'h0, ones});
    endfunction

    nasw_pkg::nasw_state_t state_reg;
    nasw_pkg::nasw_state_t state_next;
    logic [nasw_pkg::SW_W-1:0] sw_val_reg;
    logic [nasw_pkg::ADDR_W-1:0] stored_addr_reg;
    logic [nasw_pkg::ADDR_W-1:0] tool_addr_reg;
    logic [nasw_pkg::ADDR_W-1:0] node_addr_reg;
    logic [nasw_pkg::ADDR_W-1:0] node_addr_next;
    logic addr_valid_reg;
    logic dup_err_reg;
    logic [2:0] slot_idx_reg;
    logic [nasw_pkg::NUM_W-1:0] next_num_reg;
    logic [nasw_pkg::SLOTS-1:0][nasw_pkg::NUM_W-1:0] unit_num_reg;
    logic [nasw_pkg::POT_W-1:0] pot_cnt_reg;
    logic maint_reg;
    logic restore_fail_reg;
    nasw_pkg::nasw_status_t status_reg;
    nasw_pkg::nasw_status_t status_next;
    logic [15:0] cyc_word_reg;
    logic cyc_valid_reg;
    logic done_reg;

    wire logic [nasw_pkg::SW_W-1:0] sw_now = sw_value(i_rotary_tens, i_rotary_ones);
    wire logic in_run = (state_reg == nasw_pkg::ST_RUN);
    wire logic in_number = (state_reg == nasw_pkg::ST_NUMBER);
    // only real slices count; extension hardware passes the bus through
    wire logic [nasw_pkg::SLOTS-1:0] counted = i_slice.present & ~i_slice.is_ext;
    wire logic slot_counted = counted[slot_idx_reg];
    wire logic last_slot = (slot_idx_reg == 3'(nasw_pkg::SLOTS - 1));
    wire logic pot_sat = (pot_cnt_reg == '1);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            nasw_pkg::ST_SAMPLE: state_next = nasw_pkg::ST_NUMBER;
            nasw_pkg::ST_NUMBER: state_next = last_slot ? nasw_pkg::ST_RUN : nasw_pkg::ST_NUMBER;
            nasw_pkg::ST_RUN: state_next = nasw_pkg::ST_RUN;
            default: state_next = nasw_pkg::ST_SAMPLE;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= nasw_pkg::ST_SAMPLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // switches are caught only in the single sample cycle after power-on
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            sw_val_reg <= nasw_pkg::SW_AUTO;
        end else if (state_reg == nasw_pkg::ST_SAMPLE) begin
            sw_val_reg <= sw_now;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            stored_addr_reg <= nasw_pkg::ADDR_RST;
            tool_addr_reg <= nasw_pkg::ADDR_RST;
        end else begin
            if (i_store_wr) begin
                stored_addr_reg <= i_store_addr;
            end
            if (i_tool_wr) begin
                tool_addr_reg <= i_tool_addr;
            end
        end
    end

    // a foreign master never looks at the switches
    assign node_addr_next = !i_master_own ? tool_addr_reg :
        (sw_val_reg == nasw_pkg::SW_AUTO) ? stored_addr_reg :
        {9'h000, sw_val_reg};

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            node_addr_reg <= nasw_pkg::ADDR_RST;
            addr_valid_reg <= 1'b0;
        end else if (in_run) begin
            node_addr_reg <= node_addr_next;
            // zero is never a usable address, so a blank store leaves the node unaddressed
            addr_valid_reg <= (node_addr_next != nasw_pkg::ADDR_RST);
        end
    end

    // sticky until the next power-on: nothing software does can clear it
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            dup_err_reg <= 1'b0;
        end else if (in_run && i_dup_detect) begin
            dup_err_reg <= 1'b1;
        end
    end

    // one slot per cycle; the switch value plays no part here
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            slot_idx_reg <= 3'h0;
            next_num_reg <= nasw_pkg::FIRST_NUM;
            unit_num_reg <= '0;
        end else if (in_number) begin
            slot_idx_reg <= slot_idx_reg + 3'h1;
            if (slot_counted) begin
                unit_num_reg[slot_idx_reg] <= next_num_reg;
                next_num_reg <= next_num_reg + 4'h1;
            end else begin
                unit_num_reg[slot_idx_reg] <= nasw_pkg::NO_NUM;
            end
        end
    end

    // saturating so a long-lived unit does not wrap back below its threshold
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            pot_cnt_reg <= '0;
            maint_reg <= 1'b0;
        end else begin
            if (i_pot_tick && !pot_sat) begin
                pot_cnt_reg <= pot_cnt_reg + 32'h1;
            end
            maint_reg <= (i_pot_limit != '0) && (pot_cnt_reg >= i_pot_limit);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            restore_fail_reg <= 1'b0;
        end else if (i_restore_done) begin
            restore_fail_reg <= i_restore_fail;
        end
    end

    // registered copy of the run state, so the pin has no decode in front of it
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (state_next == nasw_pkg::ST_RUN);
        end
    end

    always_comb begin
        status_next = nasw_pkg::STATUS_RST;
        status_next.bus_err = i_bus_comm_err;
        status_next.warn = |(i_slice.warn & counted);
        status_next.alarm = |(i_slice.alarm & counted);
        status_next.maint = maint_reg;
        status_next.restore_fail = restore_fail_reg;
        status_next.unit_err = |status_next[13:0];
        status_next.io_refresh = in_run && i_io_exchange && !dup_err_reg;
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            status_reg <= nasw_pkg::STATUS_RST;
            cyc_word_reg <= nasw_pkg::STATUS_RST;
            cyc_valid_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            cyc_valid_reg <= i_cyc_req;
            if (i_cyc_req) begin
                cyc_word_reg <= status_reg;
            end
        end
    end

    assign o_node_addr = node_addr_reg;
    assign o_addr_valid = addr_valid_reg;
    assign o_addr_error = dup_err_reg;
    assign o_numbering_done = done_reg;
    assign o_unit_num = unit_num_reg;
    assign o_status_word = status_reg;
    assign o_cyc_word = cyc_word_reg;
    assign o_cyc_valid = cyc_valid_reg;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    sequence s_walk;
        in_number [*8] ##1 in_run;
    endsequence

    sequence s_dup_then_stop;
        dup_err_reg ##1 !status_reg.io_refresh;
    endsequence

    a_sw_decode: assert property (
        state_reg == nasw_pkg::ST_SAMPLE |=> sw_val_reg == $past(sw_now))
        else $error("switch digits decoded wrongly");
    a_sw_direct: assert property (
        in_run && i_master_own && sw_val_reg != 7'h00 |=> node_addr_reg == {9'h000, sw_val_reg})
        else $error("switch address not used");
    a_sw_stored: assert property (
        in_run && i_master_own && sw_val_reg == 7'h00 |=> node_addr_reg == $past(stored_addr_reg))
        else $error("stored address not used");
    a_foreign_tool: assert property (
        in_run && !i_master_own |=> node_addr_reg == $past(tool_addr_reg))
        else $error("tool address not used");
    a_sw_frozen: assert property (
        state_reg != nasw_pkg::ST_SAMPLE |=> $stable(sw_val_reg))
        else $error("switches resampled after power-on");
    a_factory_zero: assert property (
        state_reg == nasw_pkg::ST_SAMPLE |-> stored_addr_reg == 16'h0000 && sw_val_reg == 7'h00)
        else $error("factory address not zero");
    a_dup_stop: assert property (
        in_run && i_dup_detect |=> s_dup_then_stop)
        else $error("duplicate address did not stop exchange");
    a_num_walk: assert property (
        state_reg == nasw_pkg::ST_SAMPLE |=> s_walk)
        else $error("numbering walk wrong length");
    a_num_count: assert property (
        in_number && slot_counted |=> next_num_reg == $past(next_num_reg) + 4'h1)
        else $error("unit number not advanced");
    a_num_skip: assert property (
        in_number && !slot_counted |=> $stable(next_num_reg))
        else $error("extension slot consumed a number");
    a_num_indep: assert property (
        in_run |=> $stable(unit_num_reg))
        else $error("unit numbers changed after startup");
    a_cyc_answer: assert property (
        i_cyc_req |=> o_cyc_valid && o_cyc_word == $past(status_reg))
        else $error("cyclic word not delivered");
    a_bus_err_bit: assert property (
        ##1 status_reg.bus_err == $past(i_bus_comm_err))
        else $error("bus error bit wrong");
    a_warn_bit: assert property (
        ##1 status_reg.warn == $past(|(i_slice.warn & counted)))
        else $error("warning bit wrong");
    a_alarm_bit: assert property (
        ##1 status_reg.alarm == $past(|(i_slice.alarm & counted)))
        else $error("alarm bit wrong");
    a_maint_bit: assert property (
        i_pot_limit != '0 && pot_cnt_reg >= i_pot_limit && $stable(i_pot_limit) |=> ##1 status_reg.maint)
        else $error("maintenance bit not set");
    a_restore_bit: assert property (
        i_restore_done |=> ##1 status_reg.restore_fail == $past(i_restore_fail, 2))
        else $error("restore bit wrong");
    a_unit_err_or: assert property (
        status_reg.unit_err == |status_reg[13:0])
        else $error("summary bit not OR of flags");
    a_io_refresh: assert property (
        !i_io_exchange || !in_run |=> !status_reg.io_refresh)
        else $error("refresh bit set while stopped");
    a_rsv_zero: assert property (
        (o_status_word & nasw_pkg::RSV_MASK) == 16'h0000)
        else $error("reserved status bits not zero");

    // pulse widths, sticky flags and values that must hold between events
    a_done_state: assert property (
        done_reg == in_run)
        else $error("numbering done flag out of step");
    a_num_first: assert property (
        state_reg == nasw_pkg::ST_SAMPLE |=> next_num_reg == nasw_pkg::FIRST_NUM)
        else $error("numbering does not start at one");
    a_addr_valid: assert property (
        in_run |=> addr_valid_reg == (node_addr_reg != nasw_pkg::ADDR_RST))
        else $error("address valid flag wrong");
    a_addr_idle: assert property (
        !in_run |=> node_addr_reg == nasw_pkg::ADDR_RST)
        else $error("address applied before startup finished");
    a_dup_sticky: assert property (
        dup_err_reg |=> dup_err_reg)
        else $error("duplicate address error cleared");
    a_cyc_pulse: assert property (
        !i_cyc_req |=> !o_cyc_valid)
        else $error("cyclic valid without request");
    a_cyc_hold: assert property (
        !i_cyc_req |=> $stable(cyc_word_reg))
        else $error("cyclic word changed without request");
    a_maint_off: assert property (
        i_pot_limit == 32'h0 |=> !maint_reg)
        else $error("maintenance flag set while disabled");
    a_restore_hold: assert property (
        !i_restore_done |=> $stable(restore_fail_reg))
        else $error("restore result changed without restore");
    a_refresh_on: assert property (
        in_run && i_io_exchange && !dup_err_reg |=> status_reg.io_refresh)
        else $error("refresh bit clear while exchanging");

endmodule

`default_nettype wire

// File: design/nasw_pkg.sv
/*
 * shared constants and types for the node address and status word block.
 * assumes one core clock and a slice bus front end that reports per-slot flags.
 */
package nasw_pkg;
    localparam int SLOTS = 8;
    localparam int NUM_W = 4;
    localparam int ADDR_W = 16;
    localparam int DIGIT_W = 4;
    localparam int SW_W = 7;
    localparam int POT_W = 32;

    // status word bit positions
    localparam int BIT_BUS_ERR = 0;
    localparam int BIT_WARN = 2;
    localparam int BIT_ALARM = 4;
    localparam int BIT_MAINT = 12;
    localparam int BIT_RESTORE = 13;
    localparam int BIT_UNIT_ERR = 14;
    localparam int BIT_IO_REFRESH = 15;
    localparam logic [15:0] RSV_MASK = 16'h0fea;

    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [SW_W-1:0] SW_AUTO = 7'h00;
    localparam logic [NUM_W-1:0] FIRST_NUM = 4'h1;
    localparam logic [NUM_W-1:0] NO_NUM = 4'h0;

    typedef enum logic [2:0] {
        ST_SAMPLE = 3'b001,
        ST_NUMBER = 3'b010,
        ST_RUN = 3'b100
    } nasw_state_t;

    typedef struct packed {
        logic io_refresh;
        logic unit_err;
        logic restore_fail;
        logic maint;
        logic [6:0] rsv_11_5;
        logic alarm;
        logic rsv_3;
        logic warn;
        logic rsv_1;
        logic bus_err;
    } nasw_status_t;

    typedef struct packed {
        logic [SLOTS-1:0] present;
        logic [SLOTS-1:0] is_ext;
        logic [SLOTS-1:0] warn;
        logic [SLOTS-1:0] alarm;
    } nasw_slice_t;
endpackage

// File: tb/nasw_cyc_master_model.sv
/*
 * behavioural fieldbus master that polls the status word as cyclic input data.
 * assumes the block's cyclic request/valid handshake and one core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module nasw_cyc_master_model (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_poll,
    input wire logic [15:0] i_cyc_word,
    input wire logic i_cyc_valid,
    output logic o_cyc_req,
    output logic [15:0] o_rx_word
);
    logic [1:0] gap_reg;

    // one request every four cycles keeps the poll slow enough to see stale words
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            gap_reg <= 2'h0;
            o_cyc_req <= 1'b0;
            o_rx_word <= 16'h0000;
        end else begin
            gap_reg <= gap_reg + 2'h1;
            o_cyc_req <= i_poll && (gap_reg == 2'h0);
            if (i_cyc_valid) begin
                o_rx_word <= i_cyc_word;
            end
        end
    end
endmodule

`default_nettype wire

// File: tb/nasw_node_status_tb_top.sv
/*
 * self-checking bench for the node address and status word block.
 * assumes the design package and a polling master model beside the block.
 */
`timescale 1ns/1ps
`default_nettype none

module nasw_node_status_tb_top;
    logic clk, rst, own, store_wr, tool_wr, dup, bus_err, tick, rdone, rfail, ioex, cyc_req, poll;
    logic [nasw_pkg::DIGIT_W-1:0] tens, ones;
    logic [15:0] store_addr, tool_addr, node_addr, status, cyc_word, rx_word, e16;
    logic [31:0] limit, unit_num;
    nasw_pkg::nasw_slice_t slice;
    logic addr_valid, addr_error, num_done, cyc_valid;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed, t, o;
    bit exp_rfail, exp_dup;

    nasw_node_status u_nasw_node_status (.i_core_clk(clk), .i_reset(rst), .i_rotary_tens(tens),
        .i_rotary_ones(ones), .i_master_own(own), .i_store_wr(store_wr), .i_store_addr(store_addr),
        .i_tool_wr(tool_wr), .i_tool_addr(tool_addr), .i_dup_detect(dup), .i_slice(slice),
        .i_bus_comm_err(bus_err), .i_pot_tick(tick), .i_pot_limit(limit), .i_restore_done(rdone),
        .i_restore_fail(rfail), .i_io_exchange(ioex), .i_cyc_req(cyc_req), .o_node_addr(node_addr),
        .o_addr_valid(addr_valid), .o_addr_error(addr_error), .o_numbering_done(num_done),
        .o_unit_num(unit_num), .o_status_word(status), .o_cyc_word(cyc_word), .o_cyc_valid(cyc_valid));

    nasw_cyc_master_model u_nasw_cyc_master_model (.i_core_clk(clk), .i_reset(rst), .i_poll(poll),
        .i_cyc_word(cyc_word), .i_cyc_valid(cyc_valid), .o_cyc_req(cyc_req), .o_rx_word(rx_word));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("CHECK FAILED cycle limit expected end seen hang");
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic power_on(input int tt, input int oo, input bit m);
        tens <= tt[3:0];
        ones <= oo[3:0];
        own <= m;
        rst <= 1'b1;
        exp_rfail = 1'b0;
        exp_dup = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        check("numbering_done", {31'h0, num_done}, 32'h0);
        repeat (2) @(posedge clk);
        check("numbering_done", {31'h0, num_done}, 32'h1);
        repeat (2) @(posedge clk);
    endtask

    // reference word built only from what the bench drives
    task automatic check_status(input bit maint);
        logic [7:0] cnt;
        cnt = slice.present & ~slice.is_ext;
        e16 = 16'h0000;
        e16[0] = bus_err;
        e16[2] = |(slice.warn & cnt);
        e16[4] = |(slice.alarm & cnt);
        e16[12] = maint;
        e16[13] = exp_rfail;
        e16[14] = |e16[13:0];
        e16[15] = ioex && !exp_dup;
        check("status_word", {16'h0000, status}, {16'h0000, e16});
    endtask

    task automatic check_units();
        logic [31:0] ev;
        int n;
        ev = 32'h0000_0000;
        n = 1;
        for (int k = 0; k < 8; k++) begin
            if (slice.present[k] && !slice.is_ext[k]) begin
                ev[4*k +: 4] = n[3:0];
                n++;
            end
        end
        check("unit_num", unit_num, ev);
    endtask

    task automatic write_addr(input bit tool, input logic [15:0] a);
        if (tool) begin tool_wr <= 1'b1; tool_addr <= a; end
        else begin store_wr <= 1'b1; store_addr <= a; end
        @(posedge clk);
        tool_wr <= 1'b0;
        store_wr <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        {rst, own, store_wr, tool_wr, dup, bus_err, tick, rdone, rfail, ioex, poll} = 11'h401;
        {tens, ones, store_addr, tool_addr, limit} = '0;
        slice = '0;
        seed = $urandom(32'h9c4d);
        slice.present = 8'($urandom());
        slice.is_ext = 8'($urandom()) & slice.present;
        t = $urandom_range(9, 1);
        o = $urandom_range(9, 0);
        power_on(t, o, 1'b1);
        check("switch_addr", {16'h0000, node_addr}, t * 10 + o);
        check_units();
        tens <= 4'h0;
        ones <= 4'h0;
        repeat (5) @(posedge clk);
        check("frozen_addr", {16'h0000, node_addr}, t * 10 + o);
        $display("test switch_address done");
        power_on(0, 0, 1'b1);
        check("factory_valid", {31'h0, addr_valid}, 32'h0);
        check("factory_addr", {16'h0000, node_addr}, 32'h0);
        check_units();
        for (int i = 0; i < 3; i++) begin
            e16 = (i == 0) ? 16'h0001 : (i == 1) ? 16'hffff : 16'(($urandom() % 65535) + 1);
            write_addr(1'b0, e16);
            check("stored_addr", {16'h0000, node_addr}, {16'h0000, e16});
            check("addr_valid", {31'h0, addr_valid}, 32'h1);
        end
        $display("test stored_address done");
        power_on($urandom_range(9, 1), 5, 1'b0);
        check_units();
        e16 = 16'($urandom());
        write_addr(1'b1, e16);
        write_addr(1'b0, ~e16);
        check("tool_addr", {16'h0000, node_addr}, {16'h0000, e16});
        $display("test foreign_master done");
        poll <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            slice.warn <= 8'($urandom());
            slice.alarm <= 8'($urandom()) & 8'($urandom());
            bus_err <= ($urandom() % 4) == 0;
            ioex <= ($urandom() % 4) != 0;
            rdone <= (i % 5) == 2;
            rfail <= (i % 10) == 2;
            @(posedge clk);
            rdone <= 1'b0;
            if ((i % 5) == 2) exp_rfail = ((i % 10) == 2);
            repeat (10) @(posedge clk);
            check_status(1'b0);
            check("cyc_word", {16'h0000, rx_word}, {16'h0000, e16});
        end
        $display("test status_word done");
        limit <= 32'h0000_0003;
        for (int i = 0; i < 3; i++) begin
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            repeat (3) @(posedge clk);
            check_status(i == 2);
        end
        $display("test maintenance done");
        dup <= 1'b1;
        @(posedge clk);
        dup <= 1'b0;
        exp_dup = 1'b1;
        repeat (3) @(posedge clk);
        check("addr_error", {31'h0, addr_error}, 32'h1);
        check_status(1'b1);
        $display("test duplicate_address done");
        conclude();
    end
endmodule

`default_nettype wire
